// >>> rtl/tc_pkg.sv
// Package with the register map, field layout, reset values and timing of the thermometer core.
// Assumes a 250 MHz system clock and a 32-bit AXI4-Lite register bus.
package tc_pkg;
	// ==========================================================
	// Register map
	localparam int unsigned ADDR_W = 8;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_TEMP = 8'h08;
	localparam logic [7:0] OFF_COUNT = 8'h0c;
	localparam logic [7:0] OFF_HIGH = 8'h10;
	localparam logic [7:0] OFF_LOW = 8'h14;
	localparam logic [7:0] OFF_BASE = 8'h18;
	localparam logic [7:0] OFF_SLOPE0 = 8'h1c;
	localparam logic [7:0] OFF_STEP = 8'h20;
	// ==========================================================
	// Field positions
	localparam int unsigned CTRL_START = 0;
	localparam int unsigned CTRL_SINGLE = 1;
	localparam int unsigned CTRL_POL = 2;
	localparam int unsigned CTRL_RDSLOPE = 3;
	localparam int unsigned ST_DONE = 0;
	localparam int unsigned ST_HIGH = 1;
	localparam int unsigned ST_LOW = 2;
	localparam int unsigned ST_BUSY = 3;
	localparam int unsigned ST_ALARM = 4;
	localparam int unsigned IMG_FRAC_POS = 7;
	// ==========================================================
	// Widths and codes
	localparam int unsigned TEMP_W = 9;
	localparam int unsigned CNT_W = 16;
	localparam logic [8:0] TEMP_MIN = 9'h192;
	localparam logic [8:0] TEMP_MAX = 9'h0fa;
	localparam logic [8:0] TEMP_STEP = 9'h001;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ==========================================================
	// Reset values
	localparam logic [8:0] HIGH_RST = 9'h050;
	localparam logic [8:0] LOW_RST = 9'h03c;
	localparam logic [15:0] BASE_RST = 16'h0100;
	localparam logic [15:0] SLOPE_RST = 16'h0040;
	localparam logic [15:0] STEP_RST = 16'h0001;
	localparam logic POL_RST = 1'b1;
	localparam logic SINGLE_RST = 1'b0;
	// ==========================================================
	// Timing
	localparam int unsigned CLK_KHZ = 250000;
	localparam int unsigned CONV_TIME_MS = 1000;
	localparam int unsigned CONV_CYCLES = CONV_TIME_MS * CLK_KHZ;
	localparam int unsigned GATE_TICKS = 1024;
endpackage : tc_pkg

// >>> rtl/conv_if.sv
// Interface between the register front end and the conversion engine.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface conv_if;
	logic start;
	logic [15:0] base_count;
	logic [15:0] slope_start;
	logic [15:0] slope_step;
	logic busy;
	logic done;
	logic [8:0] temp;
	logic [15:0] remain;
	logic [15:0] slope;
	modport ctrl (output start, output base_count, output slope_start, output slope_step,
		input busy, input done, input temp, input remain, input slope);
	modport engine (input start, input base_count, input slope_start, input slope_step,
		output busy, output done, output temp, output remain, output slope);
endinterface : conv_if
`default_nettype wire

// >>> rtl/conv_engine.sv
// Counter-based conversion engine: gate from the hot oscillator, counts from the stable one.
// Assumes both oscillators arrive as asynchronous pins, far slower than the system clock.
`timescale 1ns/1ps
`default_nettype none
module conv_engine #(
	parameter int unsigned GATE_TICKS = tc_pkg::GATE_TICKS,
	parameter int unsigned TIMEOUT_CYCLES = tc_pkg::CONV_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic count_osc_pin,
	input wire logic gate_osc_pin,
	conv_if.engine cv
);
	localparam int unsigned GATE_W = $clog2(GATE_TICKS + 1);
	localparam int unsigned TMR_W = $clog2(TIMEOUT_CYCLES + 1);
	typedef enum logic [1:0] {IDLE = 2'b01, RUN = 2'b10} conv_state_e;
	conv_state_e state_reg;
	logic [1:0] pins;
	logic [2:0] sync_reg [2];
	logic [1:0] level_reg;
	logic [1:0] rise;
	logic [15:0] cnt_reg;
	logic [15:0] slope_reg;
	logic [8:0] temp_reg;
	logic [15:0] remain_reg;
	logic busy_reg;
	logic done_reg;
	logic [GATE_W-1:0] gate_reg;
	logic [TMR_W-1:0] tmr_reg;
	logic gate_end;
	assign pins = {gate_osc_pin, count_osc_pin};
	// ==========================================================
	// Pin synchronisers
	// A level counts only once the second and third stages agree, which filters a metastable sample.
	for (genvar i = 0; i < 2; i++) begin : g_sync
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				sync_reg[i] <= 3'h0;
				level_reg[i] <= 1'b0;
			end else begin
				sync_reg[i] <= {sync_reg[i][1:0], pins[i]};
				if (sync_reg[i][1] == sync_reg[i][2]) begin
					level_reg[i] <= sync_reg[i][2];
				end
			end
		end
		assign rise[i] = (sync_reg[i][1] == sync_reg[i][2]) && sync_reg[i][2] && !level_reg[i];
	end
	// ==========================================================
	// Conversion sequence
	// The timer ends a conversion whose gate oscillator has stalled, so one never hangs.
	assign gate_end = (rise[1] && gate_reg == GATE_W'(GATE_TICKS - 1)) || tmr_reg == TMR_W'(TIMEOUT_CYCLES - 1);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= IDLE;
			cnt_reg <= 16'h0000;
			slope_reg <= 16'h0000;
			temp_reg <= tc_pkg::TEMP_MIN;
			remain_reg <= 16'h0000;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			gate_reg <= '0;
			tmr_reg <= '0;
		end else begin
			done_reg <= 1'b0;
			if (cv.start) begin
				state_reg <= RUN;
				busy_reg <= 1'b1;
				cnt_reg <= cv.base_count;
				temp_reg <= tc_pkg::TEMP_MIN;
				slope_reg <= cv.slope_start;
				gate_reg <= '0;
				tmr_reg <= '0;
			end else begin
				case (state_reg)
					IDLE: begin
						busy_reg <= 1'b0;
					end
					RUN: begin
						tmr_reg <= tmr_reg + TMR_W'(1);
						if (rise[1]) begin
							gate_reg <= gate_reg + GATE_W'(1);
						end
						if (gate_end) begin
							remain_reg <= cnt_reg;
							done_reg <= 1'b1;
							busy_reg <= 1'b0;
							state_reg <= IDLE;
						end else if (rise[0]) begin
							if (cnt_reg <= 16'h0001) begin
								cnt_reg <= slope_reg;
								slope_reg <= slope_reg + cv.slope_step;
								if (temp_reg != tc_pkg::TEMP_MAX) begin
									temp_reg <= temp_reg + tc_pkg::TEMP_STEP;
								end
							end else begin
								cnt_reg <= cnt_reg - 16'h0001;
							end
						end
					end
					default: begin
						state_reg <= IDLE;
					end
				endcase
			end
		end
	end
	assign cv.busy = busy_reg;
	assign cv.done = done_reg;
	assign cv.temp = temp_reg;
	assign cv.remain = remain_reg;
	assign cv.slope = slope_reg;
endmodule : conv_engine
`default_nettype wire

// >>> rtl/temp_thermostat.sv
// Top of the thermometer and thermostat core: AXI4-Lite registers, run control and alarm.
// Assumes a single 250 MHz clock, a synchronous active-low reset and an AXI4-Lite master.
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module temp_thermostat #(
	parameter int unsigned GATE_TICKS = tc_pkg::GATE_TICKS,
	parameter int unsigned CONV_TIMEOUT_CYCLES = tc_pkg::CONV_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [tc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [tc_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic count_osc_pin,
	input wire logic gate_osc_pin,
	output logic alarm_out
);
	conv_if cv ();
	logic awready_reg;
	logic wready_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic arready_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;
	logic aw_full_reg;
	logic w_full_reg;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic wr_fire;
	logic [7:0] wa_word;
	logic [31:0] wr_merged;
	logic single_reg;
	logic pol_reg;
	logic [8:0] high_reg;
	logic [8:0] low_reg;
	logic [15:0] base_reg;
	logic [15:0] slope0_reg;
	logic [15:0] step_reg;
	logic start_reg;
	logic running_reg;
	logic done_reg;
	logic high_flag_reg;
	logic low_flag_reg;
	logic [8:0] result_reg;
	logic [15:0] count_reg;
	logic alarm_active_reg;
	logic alarm_out_reg;
	logic ctrl_wr;
	logic status_wr;
	logic start_cmd;
	logic slope_cmd;
	logic at_high;
	logic at_low;

	// ==========================================================
	// Conversion engine
	conv_engine #(
		.GATE_TICKS(GATE_TICKS),
		.TIMEOUT_CYCLES(CONV_TIMEOUT_CYCLES)
	) u_engine (
		.aclk(aclk),
		.aresetn(aresetn),
		.count_osc_pin(count_osc_pin),
		.gate_osc_pin(gate_osc_pin),
		.cv(cv.engine)
	);
	assign cv.start = start_reg;
	assign cv.base_count = base_reg;
	assign cv.slope_start = slope0_reg;
	assign cv.slope_step = step_reg;

	// ==========================================================
	// Register read view
	function automatic logic [31:0] reg_view(input logic [7:0] addr);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (addr)
			tc_pkg::OFF_CTRL: begin
				v[tc_pkg::CTRL_SINGLE] = single_reg;
				v[tc_pkg::CTRL_POL] = pol_reg;
			end
			tc_pkg::OFF_STATUS: begin
				v[tc_pkg::ST_DONE] = done_reg;
				v[tc_pkg::ST_HIGH] = high_flag_reg;
				v[tc_pkg::ST_LOW] = low_flag_reg;
				v[tc_pkg::ST_BUSY] = cv.busy;
				v[tc_pkg::ST_ALARM] = alarm_active_reg;
			end
			tc_pkg::OFF_TEMP: begin
				v[15:8] = result_reg[8:1];
				v[tc_pkg::IMG_FRAC_POS] = result_reg[0];
			end
			tc_pkg::OFF_COUNT: v[15:0] = count_reg;
			tc_pkg::OFF_HIGH: v[8:0] = high_reg;
			tc_pkg::OFF_LOW: v[8:0] = low_reg;
			tc_pkg::OFF_BASE: v[15:0] = base_reg;
			tc_pkg::OFF_SLOPE0: v[15:0] = slope0_reg;
			tc_pkg::OFF_STEP: v[15:0] = step_reg;
			default: v = 32'h0000_0000;
		endcase
		return v;
	endfunction : reg_view

	function automatic logic mapped(input logic [7:0] addr);
		logic m;
		m = 1'b0;
		case (addr)
			tc_pkg::OFF_CTRL, tc_pkg::OFF_STATUS, tc_pkg::OFF_TEMP, tc_pkg::OFF_COUNT,
			tc_pkg::OFF_HIGH, tc_pkg::OFF_LOW, tc_pkg::OFF_BASE, tc_pkg::OFF_SLOPE0,
			tc_pkg::OFF_STEP: m = 1'b1;
			default: m = 1'b0;
		endcase
		return m;
	endfunction : mapped

	function automatic logic [31:0] lane_mask(input logic [3:0] strb);
		logic [31:0] m;
		m = 32'h0000_0000;
		for (int b = 0; b < 4; b++) begin
			m[b*8 +: 8] = {8{strb[b]}};
		end
		return m;
	endfunction : lane_mask

	// ==========================================================
	// Write channels
	// Address and data are caught independently, so the master may present them in either order.
	assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
	assign wa_word = {aw_addr_reg[7:2], 2'b00};
	assign wr_merged = (reg_view(wa_word) & ~lane_mask(w_strb_reg)) | (w_data_reg & lane_mask(w_strb_reg));
	assign ctrl_wr = wr_fire && wa_word == tc_pkg::OFF_CTRL;
	assign status_wr = wr_fire && wa_word == tc_pkg::OFF_STATUS;
	assign start_cmd = ctrl_wr && wr_merged[tc_pkg::CTRL_START];
	assign slope_cmd = ctrl_wr && wr_merged[tc_pkg::CTRL_RDSLOPE];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_reg <= 1'b1;
			aw_full_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
		end else if (s_axi_awvalid && awready_reg) begin
			awready_reg <= 1'b0;
			aw_full_reg <= 1'b1;
			aw_addr_reg <= 8'(s_axi_awaddr);
		end else if (wr_fire) begin
			aw_full_reg <= 1'b0;
		end else if (bvalid_reg && s_axi_bready) begin
			awready_reg <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready_reg <= 1'b1;
			w_full_reg <= 1'b0;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
		end else if (s_axi_wvalid && wready_reg) begin
			wready_reg <= 1'b0;
			w_full_reg <= 1'b1;
			w_data_reg <= s_axi_wdata;
			w_strb_reg <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_full_reg <= 1'b0;
		end else if (bvalid_reg && s_axi_bready) begin
			wready_reg <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= tc_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= mapped(wa_word) ? tc_pkg::RESP_OKAY : tc_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	// ==========================================================
	// Read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= tc_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && arready_reg) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b1;
			rdata_reg <= reg_view({s_axi_araddr[7:2], 2'b00});
			rresp_reg <= mapped({s_axi_araddr[7:2], 2'b00}) ? tc_pkg::RESP_OKAY : tc_pkg::RESP_SLVERR;
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg <= 1'b0;
			arready_reg <= 1'b1;
		end
	end

	// ==========================================================
	// Configuration registers
	// Without a nonvolatile store the polarity falls back to its reset default after power loss.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			single_reg <= tc_pkg::SINGLE_RST;
			pol_reg <= tc_pkg::POL_RST;
		end else if (ctrl_wr) begin
			single_reg <= wr_merged[tc_pkg::CTRL_SINGLE];
			pol_reg <= wr_merged[tc_pkg::CTRL_POL];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			high_reg <= tc_pkg::HIGH_RST;
			low_reg <= tc_pkg::LOW_RST;
			base_reg <= tc_pkg::BASE_RST;
			slope0_reg <= tc_pkg::SLOPE_RST;
			step_reg <= tc_pkg::STEP_RST;
		end else if (wr_fire) begin
			case (wa_word)
				tc_pkg::OFF_HIGH: high_reg <= wr_merged[8:0];
				tc_pkg::OFF_LOW: low_reg <= wr_merged[8:0];
				tc_pkg::OFF_BASE: base_reg <= wr_merged[15:0];
				tc_pkg::OFF_SLOPE0: slope0_reg <= wr_merged[15:0];
				tc_pkg::OFF_STEP: step_reg <= wr_merged[15:0];
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Run control
	// A start while a conversion is under way restarts it from the preset values.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			start_reg <= 1'b0;
			running_reg <= 1'b0;
		end else begin
			start_reg <= start_cmd || (cv.done && running_reg && !single_reg);
			if (start_cmd) begin
				running_reg <= 1'b1;
			end else if (cv.done && single_reg) begin
				running_reg <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Result, count and status
	assign at_high = $signed(cv.temp) >= $signed(high_reg);
	assign at_low = $signed(cv.temp) <= $signed(low_reg);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			result_reg <= tc_pkg::TEMP_MIN;
			count_reg <= 16'h0000;
		end else begin
			if (cv.done) begin
				result_reg <= cv.temp;
			end
			if (slope_cmd) begin
				count_reg <= cv.slope;
			end else if (cv.done) begin
				count_reg <= cv.remain;
			end
		end
	end

	// A hardware set in the same cycle as a software clear wins, so no event is lost.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			done_reg <= 1'b0;
			high_flag_reg <= 1'b0;
			low_flag_reg <= 1'b0;
		end else begin
			if (cv.done) begin
				done_reg <= 1'b1;
			end else if (start_reg) begin
				done_reg <= 1'b0;
			end
			if (cv.done && at_high) begin
				high_flag_reg <= 1'b1;
			end else if (status_wr && !wr_merged[tc_pkg::ST_HIGH]) begin
				high_flag_reg <= 1'b0;
			end
			if (cv.done && at_low) begin
				low_flag_reg <= 1'b1;
			end else if (status_wr && !wr_merged[tc_pkg::ST_LOW]) begin
				low_flag_reg <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Thermostat
	// The alarm state moves only on a completed conversion and holds otherwise.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			alarm_active_reg <= 1'b0;
		end else if (cv.done) begin
			if (at_high) begin
				alarm_active_reg <= 1'b1;
			end else if ($signed(cv.temp) < $signed(low_reg)) begin
				alarm_active_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			alarm_out_reg <= !tc_pkg::POL_RST;
		end else begin
			alarm_out_reg <= pol_reg ? alarm_active_reg : !alarm_active_reg;
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign alarm_out = alarm_out_reg;
endmodule : temp_thermostat
`default_nettype wire

// >>> verif/temp_thermostat_sva.sv
// Checker for the register bus handshakes of the thermometer core.
// Assumes it is bound to temp_thermostat and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module temp_thermostat_sva (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [tc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [tc_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic alarm_out
);
	// ==========================================================
	// Handshakes
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_aw_taken: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("awready high after address taken");
	a_w_taken: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
		else $error("wready high after data taken");
	a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("bvalid held after response");
	a_b_back: assert property (s_axi_bvalid && s_axi_bready |=> (s_axi_awready && s_axi_wready))
		else $error("write ready not restored");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	a_ar_back: assert property (s_axi_rvalid && s_axi_rready |=> s_axi_arready && !s_axi_rvalid)
		else $error("read ready not restored");
	a_rd_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] > 6'h08
		|=> s_axi_rresp == tc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	a_rd_ok: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] <= 6'h08
		|=> s_axi_rresp == tc_pkg::RESP_OKAY)
		else $error("mapped read refused");
	// ==========================================================
	// Thermostat pin
	// This one must see the reset edges themselves, so it overrides the default disable.
	a_alarm_reset: assert property (@(posedge aclk) disable iff (1'b0) !aresetn |=> alarm_out == !tc_pkg::POL_RST)
		else $error("alarm active after reset");
endmodule : temp_thermostat_sva
`default_nettype wire

// >>> verif/osc_model.sv
// Model of the two sensor oscillators feeding the conversion pins.
// Assumes half periods given in system clock cycles; edges land off the clock edge.
`timescale 1ns/1ps
`default_nettype none
module osc_model (
	input wire logic aclk,
	input wire logic [7:0] count_half,
	input wire logic [7:0] gate_half,
	output logic count_osc_pin,
	output logic gate_osc_pin
);
	// ==========================================================
	// Free running oscillators
	// The gate runs slower than the count; the ratio sets the measured temperature.
	initial begin
		count_osc_pin = 1'b0;
		forever begin
			repeat (count_half) @(posedge aclk);
			#1 count_osc_pin = ~count_osc_pin;
		end
	end
	initial begin
		gate_osc_pin = 1'b0;
		forever begin
			repeat (gate_half) @(posedge aclk);
			#1.5 gate_osc_pin = ~gate_osc_pin;
		end
	end
endmodule : osc_model
`default_nettype wire

// >>> verif/tb_temp_thermostat.sv
// Testbench for the thermometer core: register sequences over AXI4-Lite.
// Assumes the oscillator model drives the sensor pins with a short gate.
`timescale 1ns/1ps
`default_nettype none
module tb_temp_thermostat;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, alarm, cpin, gpin;
	logic [7:0] awaddr, araddr, gate_half;
	logic [31:0] wdata, rdata, rdat;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, brsp, rrsp;
	int miscompares, comparisons;
	logic [7:0] ra [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
	logic [31:0] rv [9] = '{32'h4, 32'h0, 32'hc900, 32'h0, 32'h50, 32'h3c, 32'h100, 32'h40, 32'h1};
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	temp_thermostat #(.GATE_TICKS(8), .CONV_TIMEOUT_CYCLES(4000)) i_temp_thermostat (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .count_osc_pin(cpin), .gate_osc_pin(gpin), .alarm_out(alarm));
	osc_model i_osc_model (.aclk(aclk), .count_half(8'h02), .gate_half(gate_half), .count_osc_pin(cpin),
		.gate_osc_pin(gpin));
	// ==========================================================
	// Tasks
	function automatic logic [31:0] img(input logic [8:0] t);
		return {16'h0, t[8:1], t[0], 7'h00};
	endfunction : img
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic final_report;
		if (miscompares == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : final_report
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit fin = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!fin) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) begin
				brsp = bresp;
				bready <= 1'b0;
				fin = 1;
			end
		end
	endtask : wr
	task automatic rd(input logic [7:0] a);
		bit fin = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!fin) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) begin
				rdat = rdata;
				rrsp = rresp;
				rready <= 1'b0;
				fin = 1;
			end
		end
	endtask : rd
	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		chk(rdat, exp);
	endtask : rc
	task automatic wait_done;
		rdat = 32'h0;
		for (int n = 0; n < 2000 && rdat[0] !== 1'b1; n++) rd(tc_pkg::OFF_STATUS);
	endtask : wait_done
	initial begin
		#200000;
		miscompares++;
		final_report();
	end
	// ==========================================================
	// Sequence
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
		{awaddr, araddr, wdata} = 48'h0;
		wstrb = 4'hf;
		gate_half = 8'd21;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 9; i++) rc(ra[i], rv[i]);
		rc(8'h40, 32'h0);
		chk({30'h0, rrsp}, {30'h0, tc_pkg::RESP_SLVERR});
		wr(8'h40, 32'h0);
		chk({30'h0, brsp}, {30'h0, tc_pkg::RESP_SLVERR});
		wr(tc_pkg::OFF_BASE, 32'ha);
		wr(tc_pkg::OFF_SLOPE0, 32'h28);
		wr(tc_pkg::OFF_STEP, 32'h0);
		wr(tc_pkg::OFF_HIGH, 32'h194);
		wr(tc_pkg::OFF_LOW, 32'h190);
		wr(tc_pkg::OFF_CTRL, 32'h7);
		wait_done();
		rc(tc_pkg::OFF_TEMP, img(9'h194));
		rc(tc_pkg::OFF_STATUS, 32'h13);
		chk({31'h0, alarm}, 32'h1);
		rd(tc_pkg::OFF_COUNT);
		chk({31'h0, rdat >= 32'h5 && rdat <= 32'h12}, 32'h1);
		wr(tc_pkg::OFF_TEMP, 32'h0);
		rc(tc_pkg::OFF_TEMP, 32'hca00);
		wr(tc_pkg::OFF_CTRL, 32'ha);
		rc(tc_pkg::OFF_COUNT, 32'h28);
		chk({31'h0, alarm}, 32'h0);
		wr(tc_pkg::OFF_CTRL, 32'h6);
		wr(tc_pkg::OFF_HIGH, 32'h1a0);
		wr(tc_pkg::OFF_CTRL, 32'h7);
		chk({31'h0, alarm}, 32'h1);
		wait_done();
		chk({31'h0, alarm}, 32'h1);
		rc(tc_pkg::OFF_STATUS, 32'h13);
		wr(tc_pkg::OFF_STATUS, 32'h0);
		rc(tc_pkg::OFF_STATUS, 32'h11);
		wr(tc_pkg::OFF_LOW, 32'h195);
		wr(tc_pkg::OFF_CTRL, 32'h7);
		wait_done();
		chk({31'h0, alarm}, 32'h0);
		rc(tc_pkg::OFF_STATUS, 32'h5);
		wr(tc_pkg::OFF_CTRL, 32'h5);
		repeat (500) @(posedge aclk);
		wr(tc_pkg::OFF_HIGH, 32'h194);
		repeat (2) @(posedge aclk);
		chk({31'h0, alarm}, 32'h0);
		for (int n = 0; n < 3000 && alarm !== 1'b1; n++) @(posedge aclk);
		chk({31'h0, alarm}, 32'h1);
		wr(tc_pkg::OFF_CTRL, 32'h6);
		wait_done();
		gate_half <= 8'd120;
		wr(tc_pkg::OFF_BASE, 32'h1);
		wr(tc_pkg::OFF_SLOPE0, 32'h1);
		wr(tc_pkg::OFF_CTRL, 32'h7);
		wait_done();
		rc(tc_pkg::OFF_TEMP, 32'h7d00);
		final_report();
	end
endmodule : tb_temp_thermostat
bind temp_thermostat temp_thermostat_sva i_temp_thermostat_sva (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .alarm_out(alarm_out));
`default_nettype wire
